/* ccl_pkg.sv */
/*
 Constants and types for the condition flag logic.
 Assumes a single clock domain and a plain register port.
*/
package ccl_pkg;
    localparam logic [1:0] CCL_FLAG_REG_IDX = 2'h0;
    localparam logic [1:0] CCL_VERDICT_IDX = 2'h1;
    localparam logic [4:0] CCL_FLAGS_RESET = 5'h00;
    localparam int CCL_BIT_C = 0;
    localparam int CCL_BIT_V = 1;
    localparam int CCL_BIT_Z = 2;
    localparam int CCL_BIT_N = 3;
    localparam int CCL_BIT_X = 4;
    localparam logic [1:0] CCL_SZ_BYTE = 2'h0;
    localparam logic [1:0] CCL_SZ_WORD = 2'h1;
    localparam logic [1:0] CCL_SZ_LONG = 2'h2;
    localparam logic [3:0] CCL_CC_T = 4'h0;
    localparam logic [3:0] CCL_CC_F = 4'h1;
    localparam logic [3:0] CCL_CC_UNSIGNED_HIGHER = 4'h2;
    localparam logic [3:0] CCL_CC_UNSIGNED_LOWER_OR_SAME = 4'h3;
    localparam logic [3:0] CCL_CC_CARRY_CLEAR = 4'h4;
    localparam logic [3:0] CCL_CC_CARRY_SET = 4'h5;
    localparam logic [3:0] CCL_CC_NOT_SAME = 4'h6;
    localparam logic [3:0] CCL_CC_SAME_VALUE_TEST = 4'h7;
    localparam logic [3:0] CCL_CC_OVF_CLEAR = 4'h8;
    localparam logic [3:0] CCL_CC_OVF_SET = 4'h9;
    localparam logic [3:0] CCL_CC_PLUS = 4'hA;
    localparam logic [3:0] CCL_CC_MINUS = 4'hB;
    localparam logic [3:0] CCL_CC_SIGNED_AT_LEAST = 4'hC;
    localparam logic [3:0] CCL_CC_SIGNED_BELOW = 4'hD;
    localparam logic [3:0] CCL_CC_SIGNED_ABOVE = 4'hE;
    localparam logic [3:0] CCL_CC_SIGNED_AT_MOST = 4'hF;

    typedef enum logic [4:0] {
        CCL_OP_NONE,
        CCL_OP_PLAIN_SUM,
        CCL_OP_SUM_WITH_EXTEND,
        CCL_OP_PLAIN_DIFFERENCE,
        CCL_OP_DIFFERENCE_WITH_EXTEND,
        CCL_OP_COMPARE,
        CCL_OP_TWOS_COMPLEMENT,
        CCL_OP_COMPLEMENT_WITH_EXTEND,
        CCL_OP_DECIMAL_SUM,
        CCL_OP_DECIMAL_DIFFERENCE,
        CCL_OP_DECIMAL_COMPLEMENT,
        CCL_OP_TRANSFER,
        CCL_OP_BITWISE_LOGIC,
        CCL_OP_QUOTIENT,
        CCL_OP_SINGLE_BIT,
        CCL_OP_ARITH_RIGHT_SHIFT,
        CCL_OP_LOGIC_RIGHT_SHIFT,
        CCL_OP_LOGIC_LEFT_SHIFT,
        CCL_OP_ARITH_LEFT_SHIFT,
        CCL_OP_PLAIN_ROTATE_RIGHT,
        CCL_OP_PLAIN_ROTATE_LEFT,
        CCL_OP_ROTATE_X_RIGHT,
        CCL_OP_ROTATE_X_LEFT
    } ccl_op_t;
endpackage : ccl_pkg

/* ccl_condition_code_logic.sv */
/*
 Condition flag logic: updates five flags after each datapath operation
 and judges a 4-bit condition code against the current flags.
 Assumes the datapath presents operands, result, size and class as
 same-clock signals with a one-cycle op_valid strobe; shift operands
 give the destination value before the shift.
*/
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ccl_condition_code_logic
    import ccl_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic op_valid,
    input wire ccl_op_t op_class,
    input wire logic [1:0] op_size,
    input wire logic [31:0] src_operand,
    input wire logic [31:0] dst_operand,
    input wire logic [31:0] result,
    input wire logic [5:0] shift_count,
    input wire logic [4:0] bit_number,
    input wire logic decimal_carry,
    input wire logic division_overflow,
    input wire logic [3:0] cond_code,
    input wire logic [1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [4:0] flags,
    output logic cond_true
);
    logic [4:0] flags_ff;
    logic [4:0] nxt_flags;
    logic cond_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    // Sign bits and zero test at operand size
    wire logic [5:0] top_idx;
    wire logic s_m;
    wire logic d_m;
    wire logic r_m;
    wire logic [31:0] size_mask;
    wire logic r_zero;
    assign top_idx = (op_size == CCL_SZ_BYTE) ? 6'h07 : (op_size == CCL_SZ_WORD) ? 6'h0F : 6'h1F;
    assign size_mask = (op_size == CCL_SZ_BYTE) ? 32'h000000FF :
                       (op_size == CCL_SZ_WORD) ? 32'h0000FFFF : 32'hFFFFFFFF;
    assign s_m = src_operand[top_idx[4:0]];
    assign d_m = dst_operand[top_idx[4:0]];
    assign r_m = result[top_idx[4:0]];
    assign r_zero = ((result & size_mask) == 32'h00000000);

    wire logic cur_c;
    wire logic cur_v;
    wire logic cur_z;
    wire logic cur_n;
    wire logic cur_x;
    assign cur_c = flags_ff[CCL_BIT_C];
    assign cur_v = flags_ff[CCL_BIT_V];
    assign cur_z = flags_ff[CCL_BIT_Z];
    assign cur_n = flags_ff[CCL_BIT_N];
    assign cur_x = flags_ff[CCL_BIT_X];

    // Arithmetic formulas
    wire logic add_v;
    wire logic add_c;
    wire logic sub_v;
    wire logic sub_c;
    wire logic neg_v;
    wire logic neg_c;
    assign add_v = (s_m & d_m & ~r_m) | (~s_m & ~d_m & r_m);
    assign add_c = (s_m & d_m) | (~r_m & d_m) | (s_m & ~r_m);
    assign sub_v = (~s_m & d_m & ~r_m) | (s_m & ~d_m & r_m);
    assign sub_c = (s_m & ~d_m) | (r_m & ~d_m) | (s_m & r_m);
    assign neg_v = d_m & r_m;
    assign neg_c = d_m | r_m;
    wire logic sticky_z;
    assign sticky_z = cur_z & r_zero;

    // Shift carry and left arithmetic overflow
    wire logic cnt_zero;
    wire logic [5:0] right_idx;
    wire logic [5:0] left_idx;
    wire logic right_out;
    wire logic left_out;
    wire logic [31:0] asl_span;
    wire logic asl_v;
    assign cnt_zero = (shift_count == 6'h00);
    assign right_idx = shift_count - 6'h01;
    assign left_idx = top_idx - shift_count + 6'h01;
    // Counts beyond the operand width read the padding as zero
    assign right_out = (right_idx <= top_idx) ? dst_operand[right_idx[4:0]] : 1'b0;
    assign left_out = (left_idx <= top_idx) ? dst_operand[left_idx[4:0]] : 1'b0;
    // Bits m..m-r must all match or the top bit changed
    assign asl_span = ~(32'hFFFFFFFF << (shift_count > top_idx ? top_idx + 6'h01 : shift_count + 6'h01))
                      << (shift_count > top_idx ? 6'h00 : top_idx - shift_count);
    assign asl_v = ((dst_operand & asl_span) != 32'h00000000) && ((dst_operand & asl_span) != asl_span);

    wire logic tested_bit;
    assign tested_bit = dst_operand[bit_number];

    // Flag update; undefined flags are kept, a legal choice for any value
    always_comb
    begin
        nxt_flags = flags_ff;
        if (op_valid)
        begin
            case (op_class)
                CCL_OP_PLAIN_SUM:
                begin
                    nxt_flags = {add_c, r_m, r_zero, add_v, add_c};
                end
                CCL_OP_SUM_WITH_EXTEND:
                begin
                    nxt_flags = {add_c, r_m, sticky_z, add_v, add_c};
                end
                CCL_OP_PLAIN_DIFFERENCE:
                begin
                    nxt_flags = {sub_c, r_m, r_zero, sub_v, sub_c};
                end
                CCL_OP_DIFFERENCE_WITH_EXTEND:
                begin
                    nxt_flags = {sub_c, r_m, sticky_z, sub_v, sub_c};
                end
                CCL_OP_COMPARE:
                begin
                    nxt_flags = {cur_x, r_m, r_zero, sub_v, sub_c};
                end
                CCL_OP_TWOS_COMPLEMENT:
                begin
                    nxt_flags = {neg_c, r_m, r_zero, neg_v, neg_c};
                end
                CCL_OP_COMPLEMENT_WITH_EXTEND:
                begin
                    nxt_flags = {neg_c, r_m, sticky_z, neg_v, neg_c};
                end
                CCL_OP_DECIMAL_SUM, CCL_OP_DECIMAL_DIFFERENCE, CCL_OP_DECIMAL_COMPLEMENT:
                begin
                    nxt_flags = {decimal_carry, cur_n, sticky_z, cur_v, decimal_carry};
                end
                CCL_OP_TRANSFER, CCL_OP_BITWISE_LOGIC:
                begin
                    nxt_flags = {cur_x, r_m, r_zero, 1'b0, 1'b0};
                end
                CCL_OP_QUOTIENT:
                begin
                    nxt_flags = {cur_x, r_m, r_zero, division_overflow, 1'b0};
                end
                CCL_OP_SINGLE_BIT:
                begin
                    nxt_flags[CCL_BIT_Z] = ~tested_bit;
                end
                CCL_OP_ARITH_RIGHT_SHIFT, CCL_OP_LOGIC_RIGHT_SHIFT:
                begin
                    nxt_flags = cnt_zero ? {cur_x, r_m, r_zero, 1'b0, 1'b0}
                                         : {right_out, r_m, r_zero, 1'b0, right_out};
                end
                CCL_OP_LOGIC_LEFT_SHIFT:
                begin
                    nxt_flags = cnt_zero ? {cur_x, r_m, r_zero, 1'b0, 1'b0}
                                         : {left_out, r_m, r_zero, 1'b0, left_out};
                end
                CCL_OP_ARITH_LEFT_SHIFT:
                begin
                    nxt_flags = cnt_zero ? {cur_x, r_m, r_zero, 1'b0, 1'b0}
                                         : {left_out, r_m, r_zero, asl_v, left_out};
                end
                CCL_OP_PLAIN_ROTATE_RIGHT:
                begin
                    nxt_flags = {cur_x, r_m, r_zero, 1'b0, cnt_zero ? 1'b0 : right_out};
                end
                CCL_OP_PLAIN_ROTATE_LEFT:
                begin
                    nxt_flags = {cur_x, r_m, r_zero, 1'b0, cnt_zero ? 1'b0 : left_out};
                end
                CCL_OP_ROTATE_X_RIGHT:
                begin
                    nxt_flags = cnt_zero ? {cur_x, r_m, r_zero, 1'b0, cur_x}
                                         : {right_out, r_m, r_zero, 1'b0, right_out};
                end
                CCL_OP_ROTATE_X_LEFT:
                begin
                    nxt_flags = cnt_zero ? {cur_x, r_m, r_zero, 1'b0, cur_x}
                                         : {left_out, r_m, r_zero, 1'b0, left_out};
                end
                default:
                begin
                    nxt_flags = flags_ff;
                end
            endcase
        end
        else if (reg_wr && reg_addr == CCL_FLAG_REG_IDX)
        begin
            // Datapath update wins over a software write in the same cycle
            nxt_flags = reg_wdata[4:0];
        end
    end

    // Condition verdict
    logic nxt_cond;
    always_comb
    begin
        nxt_cond = 1'b0;
        case (cond_code)
            CCL_CC_T: nxt_cond = 1'b1;
            CCL_CC_F: nxt_cond = 1'b0;
            CCL_CC_UNSIGNED_HIGHER: nxt_cond = ~cur_c & ~cur_z;
            CCL_CC_UNSIGNED_LOWER_OR_SAME: nxt_cond = cur_c | cur_z;
            CCL_CC_CARRY_CLEAR: nxt_cond = ~cur_c;
            CCL_CC_CARRY_SET: nxt_cond = cur_c;
            CCL_CC_NOT_SAME: nxt_cond = ~cur_z;
            CCL_CC_SAME_VALUE_TEST: nxt_cond = cur_z;
            CCL_CC_OVF_CLEAR: nxt_cond = ~cur_v;
            CCL_CC_OVF_SET: nxt_cond = cur_v;
            CCL_CC_PLUS: nxt_cond = ~cur_n;
            CCL_CC_MINUS: nxt_cond = cur_n;
            CCL_CC_SIGNED_AT_LEAST: nxt_cond = (cur_n & cur_v) | (~cur_n & ~cur_v);
            CCL_CC_SIGNED_BELOW: nxt_cond = (cur_n & ~cur_v) | (~cur_n & cur_v);
            CCL_CC_SIGNED_ABOVE: nxt_cond = (cur_n & cur_v & ~cur_z) | (~cur_n & ~cur_v & ~cur_z);
            CCL_CC_SIGNED_AT_MOST: nxt_cond = cur_z | (cur_n & ~cur_v) | (~cur_n & cur_v);
            default: nxt_cond = 1'b0;
        endcase
    end

    assign nxt_rdata = !reg_rd ? 32'h00000000 :
                       (reg_addr == CCL_FLAG_REG_IDX) ? {27'h0000000, flags_ff} :
                       (reg_addr == CCL_VERDICT_IDX) ? {31'h00000000, cond_ff} : 32'h00000000;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            flags_ff <= CCL_FLAGS_RESET;
            cond_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end
        else
        begin
            flags_ff <= nxt_flags;
            cond_ff <= nxt_cond;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign flags = flags_ff;
    assign cond_true = cond_ff;

    a_sum_carry: assert property (@(posedge mclk) disable iff (!resetn)
        op_valid && op_class == CCL_OP_PLAIN_SUM |=> flags[CCL_BIT_C] == $past(add_c) && flags[CCL_BIT_X] == $past(add_c))
        else $error("sum carry wrong");
    a_sub_borrow: assert property (@(posedge mclk) disable iff (!resetn)
        op_valid && op_class == CCL_OP_PLAIN_DIFFERENCE |=> flags[CCL_BIT_C] == $past(sub_c))
        else $error("difference borrow wrong");
    a_cmp_keeps_x: assert property (@(posedge mclk) disable iff (!resetn)
        op_valid && op_class == CCL_OP_COMPARE |=> $stable(flags[CCL_BIT_X]))
        else $error("compare changed extend");
    a_logic_clears_vc: assert property (@(posedge mclk) disable iff (!resetn)
        op_valid && (op_class == CCL_OP_TRANSFER || op_class == CCL_OP_BITWISE_LOGIC)
        |=> flags[1:0] == 2'h0 && $stable(flags[CCL_BIT_X]))
        else $error("logic op flags wrong");
    a_sticky_zero: assert property (@(posedge mclk) disable iff (!resetn)
        op_valid && op_class == CCL_OP_SUM_WITH_EXTEND && !flags[CCL_BIT_Z] |=> !flags[CCL_BIT_Z])
        else $error("zero set by extend op");
    a_bit_test: assert property (@(posedge mclk) disable iff (!resetn)
        op_valid && op_class == CCL_OP_SINGLE_BIT
        |=> flags[CCL_BIT_Z] == !$past(tested_bit) && flags[4:3] == $past(flags[4:3]))
        else $error("bit test flags wrong");
    a_rox_zero_cnt: assert property (@(posedge mclk) disable iff (!resetn)
        op_valid && op_class == CCL_OP_ROTATE_X_LEFT && cnt_zero |=> flags[CCL_BIT_C] == flags[CCL_BIT_X])
        else $error("zero count rotate carry");
    a_eq_verdict: assert property (@(posedge mclk) disable iff (!resetn)
        cond_code == CCL_CC_SAME_VALUE_TEST |=> cond_true == $past(flags[CCL_BIT_Z]))
        else $error("equal verdict wrong");
    a_ge_verdict: assert property (@(posedge mclk) disable iff (!resetn)
        cond_code == CCL_CC_SIGNED_AT_LEAST |=> cond_true == ($past(flags[CCL_BIT_N]) == $past(flags[CCL_BIT_V])))
        else $error("signed at least wrong");
    a_hi_verdict: assert property (@(posedge mclk) disable iff (!resetn)
        cond_code == CCL_CC_UNSIGNED_HIGHER |=> cond_true == !($past(flags[CCL_BIT_C]) || $past(flags[CCL_BIT_Z])))
        else $error("unsigned higher wrong");
    a_false_code: assert property (@(posedge mclk) disable iff (!resetn)
        cond_code == CCL_CC_F |=> !cond_true)
        else $error("false code true");
    c_add_overflow: cover property (@(posedge mclk) disable iff (!resetn)
        op_valid && op_class == CCL_OP_PLAIN_SUM ##1 flags[CCL_BIT_V]);
    c_asl_overflow: cover property (@(posedge mclk) disable iff (!resetn)
        op_valid && op_class == CCL_OP_ARITH_LEFT_SHIFT ##1 flags[CCL_BIT_V]);
    c_le_true: cover property (@(posedge mclk) disable iff (!resetn)
        cond_code == CCL_CC_SIGNED_AT_MOST ##1 cond_true);
endmodule : ccl_condition_code_logic
`default_nettype wire

/* ccl_dp_model.sv */
/*
 Datapath stand-in: turns a one-cycle request into an op_valid
 strobe with operands and result. Assumes req is never high two
 cycles running.
*/
`timescale 1ns/1ps
`default_nettype none
module ccl_dp_model
    import ccl_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic req,
    input wire ccl_op_t req_class,
    input wire logic [1:0] req_size,
    input wire logic [31:0] req_src,
    input wire logic [31:0] req_dst,
    input wire logic xin,
    output logic op_valid,
    output var ccl_op_t op_class,
    output logic [1:0] op_size,
    output logic [31:0] src_operand,
    output logic [31:0] dst_operand,
    output logic [31:0] result,
    output logic [5:0] shift_count,
    output logic [4:0] bit_number,
    output logic decimal_carry,
    output logic division_overflow
);
    logic [31:0] nxt_result;
    logic [31:0] xv;
    assign xv = {31'h0, xin};
    // Decimal results are a binary stand-in; only their bits matter here
    always_comb
    begin
        case (req_class)
            CCL_OP_PLAIN_SUM, CCL_OP_DECIMAL_SUM: nxt_result = req_dst + req_src;
            CCL_OP_SUM_WITH_EXTEND: nxt_result = req_dst + req_src + xv;
            CCL_OP_PLAIN_DIFFERENCE, CCL_OP_COMPARE, CCL_OP_DECIMAL_DIFFERENCE: nxt_result = req_dst - req_src;
            CCL_OP_DIFFERENCE_WITH_EXTEND: nxt_result = req_dst - req_src - xv;
            CCL_OP_TWOS_COMPLEMENT, CCL_OP_DECIMAL_COMPLEMENT: nxt_result = 32'h0 - req_dst;
            CCL_OP_COMPLEMENT_WITH_EXTEND: nxt_result = 32'h0 - req_dst - xv;
            CCL_OP_BITWISE_LOGIC: nxt_result = req_dst & req_src;
            CCL_OP_TRANSFER: nxt_result = req_src;
            default: nxt_result = req_dst;
        endcase
    end
    // Idle operands toggle so stale values never look valid
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            op_valid <= 1'b0;
            op_class <= CCL_OP_NONE;
            op_size <= 2'h0;
            src_operand <= 32'h0;
            dst_operand <= 32'h0;
            result <= 32'h0;
            shift_count <= 6'h00;
            bit_number <= 5'h00;
            decimal_carry <= 1'b0;
            division_overflow <= 1'b0;
        end
        else if (req)
        begin
            op_valid <= 1'b1;
            op_class <= req_class;
            op_size <= req_size;
            src_operand <= req_src;
            dst_operand <= req_dst;
            result <= nxt_result;
            bit_number <= req_src[4:0];
            shift_count <= req_src[13:8];
            decimal_carry <= req_src[1];
            division_overflow <= req_src[2];
        end
        else
        begin
            op_valid <= 1'b0;
            src_operand <= ~src_operand;
            dst_operand <= ~dst_operand;
            result <= ~result;
        end
    end
endmodule : ccl_dp_model
`default_nettype wire

/* ccl_condition_code_logic_tb.sv */
/*
 Self-checking bench for the condition flag logic.
 Assumes ccl_pkg and ccl_dp_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module ccl_condition_code_logic_tb
    import ccl_pkg::*;
();
    typedef struct {int due; int kind; logic [31:0] val;} ccl_note_t;
    logic mclk = 1'b0;
    logic resetn, req, op_valid, reg_wr, reg_rd, cond_true, decimal_carry, division_overflow;
    ccl_op_t req_class, op_class;
    logic [1:0] req_size, op_size, reg_addr;
    logic [31:0] req_src, req_dst, src_operand, dst_operand, result, reg_wdata, reg_rdata;
    logic [5:0] shift_count;
    logic [4:0] bit_number, flags, shadow;
    logic [3:0] cond_code;
    int error_cnt = 0, num_checks = 0, cyc = 0, seed = 65;
    ccl_note_t q[$];
    ccl_op_t tbl[21] = '{CCL_OP_PLAIN_SUM, CCL_OP_SUM_WITH_EXTEND, CCL_OP_PLAIN_DIFFERENCE,
        CCL_OP_DIFFERENCE_WITH_EXTEND, CCL_OP_COMPARE, CCL_OP_TWOS_COMPLEMENT, CCL_OP_COMPLEMENT_WITH_EXTEND,
        CCL_OP_DECIMAL_SUM, CCL_OP_DECIMAL_DIFFERENCE, CCL_OP_TRANSFER, CCL_OP_QUOTIENT, CCL_OP_SINGLE_BIT,
        CCL_OP_BITWISE_LOGIC, CCL_OP_ARITH_RIGHT_SHIFT, CCL_OP_LOGIC_RIGHT_SHIFT, CCL_OP_LOGIC_LEFT_SHIFT,
        CCL_OP_ARITH_LEFT_SHIFT, CCL_OP_PLAIN_ROTATE_RIGHT, CCL_OP_PLAIN_ROTATE_LEFT, CCL_OP_ROTATE_X_RIGHT,
        CCL_OP_ROTATE_X_LEFT};

    always #4 mclk = ~mclk;

    ccl_dp_model dp (.mclk, .resetn, .req, .req_class, .req_size, .req_src, .req_dst, .xin(flags[CCL_BIT_X]),
        .op_valid, .op_class, .op_size, .src_operand, .dst_operand, .result, .shift_count, .bit_number,
        .decimal_carry, .division_overflow);
    ccl_condition_code_logic uut (.mclk, .resetn, .op_valid, .op_class, .op_size, .src_operand, .dst_operand,
        .result, .shift_count, .bit_number, .decimal_carry, .division_overflow, .cond_code, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flags, .cond_true);

    function automatic logic [4:0] exp_flags(ccl_op_t c, logic [1:0] z, logic [31:0] s, d, r,
        logic [4:0] o, logic dc, logic dv, logic [4:0] bn, int sc);
        int t;
        int lo;
        logic sm, dm, rm, zr, add, sub, neg, dec, clr, stk, v, cy, x, n, zf;
        logic sh, rt, rox, bo, a1, a0;
        t = (z == CCL_SZ_BYTE) ? 7 : (z == CCL_SZ_WORD) ? 15 : 31;
        sm = s[t];
        dm = d[t];
        rm = r[t];
        zr = ((r << (31 - t)) == 32'h0);
        add = c inside {CCL_OP_PLAIN_SUM, CCL_OP_SUM_WITH_EXTEND};
        sub = c inside {CCL_OP_PLAIN_DIFFERENCE, CCL_OP_DIFFERENCE_WITH_EXTEND, CCL_OP_COMPARE};
        neg = c inside {CCL_OP_TWOS_COMPLEMENT, CCL_OP_COMPLEMENT_WITH_EXTEND};
        dec = c inside {CCL_OP_DECIMAL_SUM, CCL_OP_DECIMAL_DIFFERENCE, CCL_OP_DECIMAL_COMPLEMENT};
        clr = c inside {CCL_OP_TRANSFER, CCL_OP_BITWISE_LOGIC, CCL_OP_QUOTIENT};
        stk = dec | (c inside {CCL_OP_SUM_WITH_EXTEND, CCL_OP_DIFFERENCE_WITH_EXTEND, CCL_OP_COMPLEMENT_WITH_EXTEND});
        sh = c inside {CCL_OP_ARITH_RIGHT_SHIFT, CCL_OP_LOGIC_RIGHT_SHIFT, CCL_OP_LOGIC_LEFT_SHIFT,
            CCL_OP_ARITH_LEFT_SHIFT, CCL_OP_PLAIN_ROTATE_RIGHT, CCL_OP_PLAIN_ROTATE_LEFT, CCL_OP_ROTATE_X_RIGHT,
            CCL_OP_ROTATE_X_LEFT};
        rt = c inside {CCL_OP_ARITH_RIGHT_SHIFT, CCL_OP_LOGIC_RIGHT_SHIFT, CCL_OP_PLAIN_ROTATE_RIGHT,
            CCL_OP_ROTATE_X_RIGHT};
        rox = c inside {CCL_OP_ROTATE_X_RIGHT, CCL_OP_ROTATE_X_LEFT};
        // Bits past the operand width shift out as zero
        lo = rt ? sc - 1 : t - sc + 1;
        bo = (lo >= 0 && lo <= t) ? d[lo] : 1'b0;
        a1 = 1'b1;
        a0 = 1'b1;
        for (int b = 0; b <= t; b++)
        begin
            if (b >= t - sc)
            begin
                a1 = a1 & d[b];
                a0 = a0 & ~d[b];
            end
        end
        cy = add ? (sm & dm | ~rm & dm | sm & ~rm) : sub ? (sm & ~dm | rm & ~dm | sm & rm) :
            neg ? (dm | rm) : dec ? dc : sh ? ((sc == 0) ? (rox & o[4]) : bo) :
            clr ? 1'b0 : o[0];
        v = add ? (sm & dm & ~rm | ~sm & ~dm & rm) : sub ? (~sm & dm & ~rm | sm & ~dm & rm) :
            neg ? (dm & rm) : (c == CCL_OP_QUOTIENT) ? dv :
            sh ? ((c == CCL_OP_ARITH_LEFT_SHIFT) && sc != 0 && !a1 && !a0) :
            clr ? 1'b0 : o[1];
        x = (add | (sub & (c != CCL_OP_COMPARE)) | neg | dec |
            (sh && sc != 0 && !(c inside {CCL_OP_PLAIN_ROTATE_RIGHT, CCL_OP_PLAIN_ROTATE_LEFT}))) ? cy : o[4];
        n = (dec | (c == CCL_OP_SINGLE_BIT)) ? o[3] : rm;
        zf = (c == CCL_OP_SINGLE_BIT) ? ~d[bn] : stk ? (o[2] & zr) : zr;
        return {x, n, zf, v, cy};
    endfunction : exp_flags

    function automatic logic cond_exp(logic [3:0] k, logic [4:0] f);
        logic c, v, z, n, nv;
        logic [15:0] tv;
        c = f[CCL_BIT_C];
        v = f[CCL_BIT_V];
        z = f[CCL_BIT_Z];
        n = f[CCL_BIT_N];
        nv = n ^ v;
        tv = {z | nv, ~z & ~nv, nv, ~nv, n, ~n, v, ~v, z, ~z, c, ~c, c | z, ~c & ~z, 1'b0, 1'b1};
        return tv[k];
    endfunction : cond_exp

    task automatic report(logic ok, logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (!ok)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : report
    task automatic cmp_flags(logic [4:0] got, logic [4:0] exp);
        report(got === exp, {27'h0, got}, {27'h0, exp});
    endtask : cmp_flags
    task automatic cmp_rdata(logic [31:0] got, logic [31:0] exp);
        report(got === exp, got, exp);
    endtask : cmp_rdata
    task automatic cmp_cond(logic got, logic exp);
        report(got === exp, {31'h0, got}, {31'h0, exp});
    endtask : cmp_cond

    task automatic note(int due, int kind, logic [31:0] val);
        q.push_back('{due, kind, val});
    endtask : note

    // Notes are matched by due cycle, so pushes in one time step never race
    always @(negedge mclk)
    begin
        int i;
        cyc++;
        i = 0;
        while (i < q.size())
        begin
            if (q[i].due == cyc)
            begin
                case (q[i].kind)
                    0: cmp_flags(flags, q[i].val[4:0]);
                    1: cmp_rdata(reg_rdata, q[i].val);
                    default: cmp_cond(cond_true, q[i].val[0]);
                endcase
                q.delete(i);
            end
            else
                i++;
        end
    end

    always @(posedge mclk)
    begin
        if (op_valid === 1'b1)
        begin
            shadow = exp_flags(op_class, op_size, src_operand, dst_operand, result, shadow,
                decimal_carry, division_overflow, bit_number, int'(shift_count));
            note(cyc + 1, 0, {27'h0, shadow});
        end
    end

    task automatic reg_write(logic [1:0] a, logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        if (a == CCL_FLAG_REG_IDX)
            shadow = d[4:0];
        note(cyc + 2, 0, {27'h0, shadow});
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(logic [1:0] a, logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        note(cyc + 2, 1, e);
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask : reg_read
    task automatic do_op(ccl_op_t c, logic [1:0] z, logic [31:0] s, logic [31:0] d);
        @(posedge mclk);
        req <= 1'b1;
        req_class <= c;
        req_size <= z;
        req_src <= s;
        req_dst <= d;
        @(posedge mclk);
        req <= 1'b0;
    endtask : do_op

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    task automatic drain(string name);
        for (int k = 0; k < 20 && q.size() != 0; k++)
            @(negedge mclk);
        if (q.size() != 0)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t pending %h expected %h", $time, q.size(), 0);
            wrap_up();
        end
        $display("test %s done", name);
    endtask : drain

    initial
    begin
        logic [31:0] s;
        logic [31:0] d;
        resetn = 1'b0;
        req = 1'b0;
        req_class = CCL_OP_NONE;
        req_size = 2'h0;
        req_src = 32'h0;
        req_dst = 32'h0;
        reg_addr = 2'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cond_code = 4'h0;
        shadow = CCL_FLAGS_RESET;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        reg_read(CCL_FLAG_REG_IDX, {27'h0, CCL_FLAGS_RESET});
        reg_write(CCL_FLAG_REG_IDX, 32'hFFFF_FFFF);
        reg_read(CCL_FLAG_REG_IDX, 32'h0000_001F);
        reg_write(2'h3, 32'h0000_0000);
        reg_write(CCL_VERDICT_IDX, 32'h0000_0000);
        reg_read(2'h3, 32'h0000_0000);
        drain("registers");
        // Zero must survive a zero result and fall on a nonzero one
        reg_write(CCL_FLAG_REG_IDX, 32'h0000_0004);
        do_op(CCL_OP_SUM_WITH_EXTEND, CCL_SZ_BYTE, 32'h0000_0000, 32'h0000_0000);
        do_op(CCL_OP_SUM_WITH_EXTEND, CCL_SZ_BYTE, 32'h0000_0080, 32'h0000_0080);
        do_op(CCL_OP_DECIMAL_SUM, CCL_SZ_BYTE, 32'h0000_0002, 32'h0000_0000);
        do_op(CCL_OP_ROTATE_X_LEFT, CCL_SZ_BYTE, 32'h0000_0000, 32'h0000_0081);
        do_op(CCL_OP_ARITH_LEFT_SHIFT, CCL_SZ_BYTE, 32'h0000_0100, 32'h0000_0040);
        drain("sticky zero");
        for (int i = 0; i < 240; i++)
        begin
            s = $random(seed);
            d = (i % 4 == 0) ? 32'h8000_8080 : $random(seed);
            do_op(tbl[i % 21], (i % 3 == 0) ? CCL_SZ_BYTE : (i % 3 == 1) ? CCL_SZ_WORD : CCL_SZ_LONG, s, d);
        end
        drain("operations");
        for (int k = 0; k < 16; k++)
        begin
            for (int j = 0; j < 4; j++)
            begin
                reg_write(CCL_FLAG_REG_IDX, $random(seed));
                @(posedge mclk);
                cond_code <= k[3:0];
                note(cyc + 2, 2, {31'h0, cond_exp(k[3:0], shadow)});
            end
            reg_read(CCL_VERDICT_IDX, {31'h0, cond_exp(k[3:0], shadow)});
        end
        drain("conditions");
        wrap_up();
    end
endmodule : ccl_condition_code_logic_tb
`default_nettype wire
